//--- hw/i2m_byte_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2m_defines.svh"

module i2m_byte_master #(
  parameter int DEF_MULT = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_clk,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import i2m_pkg::*;

  if (DEF_MULT < 1 || DEF_MULT > 255) begin : g_bad_mult
    $error("DEF_MULT must lie in 1..255");
  end

  // ---------------- register side, aclk ----------------
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic busy_q;
  logic req_tog_q;
  i2m_cmd_t cmd_q;
  i2m_res_t res_q;
  logic [7:0] mult_q;
  logic [15:0] rate_q;
  logic [15:0] qcnt_q;
  logic [15:0] qcnt_d;
  logic [31:0] rate_den;
  logic [31:0] rate_q32;
  logic done_s1_q, done_s2_q, done_s3_q;
  logic done_evt;
  i2m_res_t res_l_q;
  logic done_tog_q;

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign done_evt = done_s2_q ^ done_s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      s_axi_awready <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_q <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (!aw_got_q && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      s_axi_wready <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_q <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (!w_got_q && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response and command launch; a command written while busy is refused
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `I2M_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_q == `I2M_OFF_CMD) begin
        s_axi_bresp <= busy_q ? `I2M_RESP_SLVERR : `I2M_RESP_OKAY;
      end else if (awaddr_q == `I2M_OFF_CFG) begin
        s_axi_bresp <= `I2M_RESP_OKAY;
      end else if (awaddr_q == `I2M_OFF_STATUS) begin
        s_axi_bresp <= `I2M_RESP_OKAY;
      end else begin
        s_axi_bresp <= `I2M_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      req_tog_q <= 1'b0;
      cmd_q <= '0;
    end else if (wr_fire && awaddr_q == `I2M_OFF_CMD && !busy_q) begin
      busy_q <= 1'b1;
      req_tog_q <= ~req_tog_q;
      cmd_q.data <= wdata_q[`I2M_CMD_DATA_LSB +: 8];
      cmd_q.start_flag <= wdata_q[`I2M_CMD_START];
      cmd_q.repeated_start_flag <= wdata_q[`I2M_CMD_RESTART];
      cmd_q.ack_drive_flag <= wdata_q[`I2M_CMD_ACK];
      cmd_q.stop_flag <= wdata_q[`I2M_CMD_STOP];
      cmd_q.op <= i2m_op_t'(wdata_q[`I2M_CMD_OP_LSB +: 2]);
      cmd_q.qcnt <= qcnt_q;
    end else if (done_evt) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mult_q <= 8'(DEF_MULT);
      rate_q <= `I2M_RATE_RESET;
    end else if (wr_fire && awaddr_q == `I2M_OFF_CFG) begin
      if (wstrb_q[0]) begin
        mult_q <= wdata_q[`I2M_CFG_MULT_LSB +: 8];
      end
      if (wstrb_q[1]) begin
        rate_q[7:0] <= wdata_q[`I2M_CFG_RATE_LSB +: 8];
      end
      if (wstrb_q[2]) begin
        rate_q[15:8] <= wdata_q[`I2M_CFG_RATE_LSB + 8 +: 8];
      end
    end
  end

  // quarter-bit length in link clocks; a rate setting overrides the multiplier
  assign rate_den = 32'(rate_q) * 32'(`I2M_LINK_PERIOD_NS);
  assign rate_q32 = (32'(`I2M_KHZ_QUARTER_NS) + rate_den - 32'h1) / rate_den;

  always_comb begin
    if (rate_q != 16'h0000) begin
      qcnt_d = (rate_q32 > 32'h0000_ffff) ? 16'hffff : rate_q32[15:0];
    end else if (mult_q == 8'h00) begin
      qcnt_d = 16'(`I2M_QBASE);
    end else begin
      qcnt_d = 16'(`I2M_QBASE * 32'(mult_q));
    end
  end

  // divider result settles one cycle after a config write; commands see it after
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qcnt_q <= 16'(`I2M_QBASE * DEF_MULT);
    end else begin
      qcnt_q <= qcnt_d;
    end
  end

  // done toggle from the link side; its result word is stable while toggle settles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_tog_q;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= '0;
    end else if (done_evt) begin
      res_q <= res_l_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `I2M_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `I2M_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      if (s_axi_araddr == `I2M_OFF_STATUS) begin
        s_axi_rdata[`I2M_ST_BUSY] <= busy_q;
        s_axi_rdata[`I2M_ST_ACK] <= res_q.ack;
        s_axi_rdata[`I2M_ST_DATA_LSB +: 8] <= res_q.data;
      end else if (s_axi_araddr == `I2M_OFF_CFG) begin
        s_axi_rdata[`I2M_CFG_MULT_LSB +: 8] <= mult_q;
        s_axi_rdata[`I2M_CFG_RATE_LSB +: 16] <= rate_q;
      end else if (s_axi_araddr == `I2M_OFF_CMD) begin
        s_axi_rdata[`I2M_CMD_DATA_LSB +: 8] <= cmd_q.data;
        s_axi_rdata[`I2M_CMD_START] <= cmd_q.start_flag;
        s_axi_rdata[`I2M_CMD_RESTART] <= cmd_q.repeated_start_flag;
        s_axi_rdata[`I2M_CMD_ACK] <= cmd_q.ack_drive_flag;
        s_axi_rdata[`I2M_CMD_STOP] <= cmd_q.stop_flag;
        s_axi_rdata[`I2M_CMD_OP_LSB +: 2] <= cmd_q.op;
      end else begin
        s_axi_rresp <= `I2M_RESP_SLVERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- link side, link_clk ----------------
  logic lrst_s1_q, lrst_s2_q;
  logic req_s1_q, req_s2_q, req_s3_q;
  logic sda_s1_q, sda_s2_q;
  i2m_state_t state_q;
  i2m_cmd_t lcmd_q;
  logic [1:0] phase_q;
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic ack_q;
  logic tick;
  logic last_slot;

  // a short reset pulse is stretched in aclk so the slower link clock still sees it
  logic [5:0] lrst_cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lrst_cnt_q <= 6'h00;
    end else if (!lrst_cnt_q[5]) begin
      lrst_cnt_q <= lrst_cnt_q + 6'h01;
    end
  end

  // only the single top bit crosses; it rises once and never glitches
  always_ff @(posedge link_clk) begin
    lrst_s1_q <= lrst_cnt_q[5];
    lrst_s2_q <= lrst_s1_q;
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_q) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      req_s1_q <= req_tog_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
    end
  end

  assign tick = (state_q != I2M_IDLE) && (cnt_q >= lcmd_q.qcnt - 16'h0001);
  assign last_slot = (lcmd_q.op == I2M_OP_ABORT) ?
    (bit_q == 4'(`I2M_DATA_BITS - 1)) : (bit_q == 4'(`I2M_ACK_SLOT));

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_q || state_q == I2M_IDLE || tick) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // open-drain: the output value is always low, only the enable moves
  always_ff @(posedge link_clk) begin
    if (!lrst_s2_q) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2_q) begin
      state_q <= I2M_IDLE;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      ack_q <= 1'b1;
      lcmd_q <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      done_tog_q <= 1'b0;
      res_l_q <= '0;
    end else begin
      case (state_q)
        I2M_IDLE: begin
          if (req_s2_q ^ req_s3_q) begin
            lcmd_q <= cmd_q;
            shift_q <= cmd_q.data;
            phase_q <= 2'h0;
            bit_q <= 4'h0;
            if (cmd_q.start_flag || cmd_q.repeated_start_flag) begin
              state_q <= I2M_LEAD;
            end else begin
              state_q <= I2M_SLOT;
            end
          end
        end
        I2M_LEAD: begin
          if (tick) begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0: sda_oe <= 1'b0;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b1;
              default: begin
                scl_oe <= 1'b1;
                state_q <= I2M_SLOT;
              end
            endcase
          end
        end
        I2M_SLOT: begin
          if (tick) begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0: begin
                // data is set up with SCL low, MSB first
                if (bit_q == 4'(`I2M_ACK_SLOT)) begin
                  sda_oe <= lcmd_q.ack_drive_flag;
                end else if (lcmd_q.op == I2M_OP_WRITE) begin
                  sda_oe <= ~shift_q[7];
                end else begin
                  sda_oe <= 1'b0;
                end
              end
              2'h1: scl_oe <= 1'b0;
              2'h2: begin
                if (bit_q == 4'(`I2M_ACK_SLOT)) begin
                  ack_q <= sda_s2_q;
                end else begin
                  shift_q <= {shift_q[6:0], sda_s2_q};
                end
              end
              default: begin
                scl_oe <= 1'b1;
                bit_q <= bit_q + 4'h1;
                if (last_slot) begin
                  if (lcmd_q.stop_flag || lcmd_q.op == I2M_OP_ABORT) begin
                    state_q <= I2M_STOP;
                  end else begin
                    state_q <= I2M_FINISH;
                  end
                end
              end
            endcase
          end
        end
        I2M_STOP: begin
          if (tick) begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0: sda_oe <= 1'b1;
              2'h1: scl_oe <= 1'b0;
              2'h2: sda_oe <= 1'b0;
              default: state_q <= I2M_FINISH;
            endcase
          end
        end
        default: begin
          res_l_q.ack <= ack_q;
          res_l_q.data <= shift_q;
          done_tog_q <= ~done_tog_q;
          state_q <= I2M_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- inc/i2m_defines.svh
`ifndef I2M_DEFINES_SVH
`define I2M_DEFINES_SVH

// register byte addresses
`define I2M_OFF_CMD 8'h00
`define I2M_OFF_STATUS 8'h04
`define I2M_OFF_CFG 8'h08

// command word fields
`define I2M_CMD_DATA_LSB 0
`define I2M_CMD_START 8
`define I2M_CMD_RESTART 9
`define I2M_CMD_ACK 10
`define I2M_CMD_STOP 11
`define I2M_CMD_OP_LSB 12
`define I2M_NO_ACTION 4'h0

// status fields
`define I2M_ST_BUSY 0
`define I2M_ST_ACK 1
`define I2M_ST_DATA_LSB 8

// config fields and reset values
`define I2M_CFG_MULT_LSB 0
`define I2M_CFG_RATE_LSB 8
`define I2M_MULT_RESET 8'h01
`define I2M_RATE_RESET 16'h0000

// axi responses
`define I2M_RESP_OKAY 2'h0
`define I2M_RESP_SLVERR 2'h2

// bus timing
`define I2M_DATA_BITS 8
`define I2M_ACK_SLOT 8
`define I2M_QUARTER_NS 625
`define I2M_KHZ_QUARTER_NS 250000
`define I2M_LINK_PERIOD_NS 64
`define I2M_QBASE ((`I2M_QUARTER_NS + `I2M_LINK_PERIOD_NS - 1) / `I2M_LINK_PERIOD_NS)

`endif

//--- inc/i2m_pkg.sv
package i2m_pkg;

  typedef enum logic [1:0] {
    I2M_OP_READ,
    I2M_OP_WRITE,
    I2M_OP_ABORT,
    I2M_OP_NONE
  } i2m_op_t;

  typedef enum logic [2:0] {
    I2M_IDLE,
    I2M_LEAD,
    I2M_SLOT,
    I2M_STOP,
    I2M_FINISH
  } i2m_state_t;

  typedef struct packed {
    i2m_op_t op;
    logic start_flag;
    logic repeated_start_flag;
    logic ack_drive_flag;
    logic stop_flag;
    logic [7:0] data;
    logic [15:0] qcnt;
  } i2m_cmd_t;

  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } i2m_res_t;

endpackage

//--- verification/i2m_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module i2m_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe
);
  // link-side flops settle a few link clocks after the register side leaves reset
  logic [2:0] lk_q = 3'h0;
  always @(posedge link_clk) begin
    if (!aresetn) begin
      lk_q <= 3'h0;
    end else if (lk_q != 3'h7) begin
      lk_q <= lk_q + 3'h1;
    end
  end
  sequence b_gap;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  AST_B_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> b_gap)
    else $error("write response not two cycles after handshake");
  AST_B_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  AST_R_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not in the cycle after address");
  AST_R_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  AST_READY_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |=> s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("address ready missing after reset");
  AST_AW_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted before response taken");
  AST_OPEN_DRAIN: assert property (@(posedge link_clk) disable iff (lk_q != 3'h7)
    !scl_o && !sda_o)
    else $error("bus line driven high");
  AST_ONE_LINE_STEP: assert property (@(posedge link_clk) disable iff (lk_q != 3'h7)
    !$stable(sda_oe) |-> $stable(scl_oe))
    else $error("data and clock lines moved together");
endmodule
`default_nettype wire

//--- verification/i2m_slave_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2m_slave_model (
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  input wire logic tx_en,
  input wire logic [7:0] tx_byte,
  output logic drv_low,
  output logic [7:0] rx_byte,
  output int starts,
  output int stops,
  output int rises
);
  int cnt = 0;
  logic nack = 0;
  logic [7:0] sh;
  initial drv_low = 0;
  always @(negedge sda) if (rst_n && scl === 1'b1) begin
    starts++;
    cnt = 0;
    nack = 0;
  end
  always @(posedge sda) if (rst_n && scl === 1'b1) begin
    stops++;
    cnt = 0;
  end
  always @(posedge scl) if (rst_n) begin
    rises++;
    if (cnt < 8) sh = {sh[6:0], sda};
    // only a full byte is handed over; the rise that opens a STOP carries no data
    if (cnt == 7) rx_byte = sh;
    if (cnt == 8) nack = sda;
    cnt++;
  end
  // a master that withheld its acknowledge ends our sending, as a real slave does
  always @(negedge scl) if (rst_n) begin
    if (cnt >= 9) cnt = 0;
    if (cnt < 8) drv_low = tx_en && !nack && !tx_byte[7 - cnt];
    else drv_low = ack_en && !tx_en;
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2m_defines.svh"
module tb;
  localparam logic [13:0] F_START = 14'h0100, F_RESTART = 14'h0200, F_ACK = 14'h0400;
  localparam logic [13:0] F_STOP = 14'h0800, OP_WR = 14'h1000, OP_AB = 14'h2000;
  logic aclk = 0, link_clk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, tx_byte = 0, rx_byte;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, st, seed = 32'h00009f56;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, ack_en = 0, tx_en = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic scl_o, scl_oe, sda_o, sda_oe, sda_i, scl, drv_low;
  int starts, stops, rises, r0, s0, p0, hi_ns, num_errors = 0, checks = 0;
  realtime t_hi;
  always #4 aclk = ~aclk;
  initial begin
    #1.7;
    forever #32 link_clk = ~link_clk;
  end
  // both lines are pulled up; the master may pull either low, the slave only SDA
  assign scl = (scl_oe === 1'b1) ? 1'b0 : 1'b1;
  assign sda_i = (sda_oe === 1'b1 || drv_low) ? 1'b0 : 1'b1;
  always @(posedge scl) t_hi = $realtime;
  always @(negedge scl) hi_ns = int'($realtime - t_hi);
  i2m_byte_master #(.DEF_MULT(1)) dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_clk, .scl_o, .scl_oe,
    .sda_i, .sda_o, .sda_oe);
  i2m_slave_model slv_u (.rst_n(aresetn), .scl, .sda(sda_i), .ack_en, .tx_en, .tx_byte,
    .drv_low, .rx_byte, .starts, .stops, .rises);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // expected scl high time: two quarter-bits of link clocks
  function automatic int exp_hi(input int mult, input int rate);
    int q;
    q = (rate != 0) ? (`I2M_KHZ_QUARTER_NS + rate * `I2M_LINK_PERIOD_NS - 1) /
        (rate * `I2M_LINK_PERIOD_NS) : `I2M_QBASE * mult;
    return 2 * q * `I2M_LINK_PERIOD_NS;
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(inout int n);
    @(posedge aclk);
    n++;
    if (n > 4000) begin
      num_errors++;
      $display("Error handshake expected within bound seen none");
      final_report;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w;
    n = 0;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    while (aw || w) begin
      step(n);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 0;
      end
    end
    // late ready lets the response wait for us
    repeat (2) step(n);
    s_axi_bready <= 1;
    do step(n); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do step(n); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    step(n);
    s_axi_rready <= 1;
    do step(n); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 0;
    chk("rresp", s_axi_rresp, er);
  endtask
  task automatic cmd(input logic [13:0] c);
    int n;
    n = 0;
    r0 = rises;
    s0 = starts;
    p0 = stops;
    wr(`I2M_OFF_CMD, {18'h0, c}, `I2M_RESP_OKAY);
    rd(`I2M_OFF_STATUS, st, `I2M_RESP_OKAY);
    chk("busy", st[0], 1'b1);
    wr(`I2M_OFF_CMD, 32'h00000000, `I2M_RESP_SLVERR);
    do begin
      rd(`I2M_OFF_STATUS, st, `I2M_RESP_OKAY);
      step(n);
    end while (st[0] !== 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    // the link side leaves its stretched reset only after several of its own edges
    repeat (64) @(posedge aclk);
    rd(`I2M_OFF_CFG, st, `I2M_RESP_OKAY);
    chk("cfg_reset", st, {8'h00, `I2M_RATE_RESET, `I2M_MULT_RESET});
    rd(8'h0c, st, `I2M_RESP_SLVERR);
    chk("unmapped_rdata", st, 32'h0);
    wr(8'h0c, 32'hffffffff, `I2M_RESP_SLVERR);
    wr(`I2M_OFF_STATUS, 32'hffffffff, `I2M_RESP_OKAY);
    $display("test registers done");
    seed = xs(seed);
    ack_en <= 1;
    cmd(F_START | F_STOP | OP_WR | {6'h0, seed[7:0]});
    chk("ack", st[1], 1'b0);
    chk("rx_byte", rx_byte, seed[7:0]);
    chk("rises", rises - r0, 10);
    chk("starts", starts - s0, 1);
    chk("stops", stops - p0, 1);
    chk("hi_ns", hi_ns, exp_hi(1, 0));
    chk("sda_oe", sda_oe, 1'b0);
    $display("test write start stop done");
    wr(`I2M_OFF_CFG, 32'h00000004, `I2M_RESP_OKAY);
    seed = xs(seed);
    ack_en <= 0;
    cmd(F_START | OP_WR | {6'h0, seed[7:0]});
    chk("nack", st[1], 1'b1);
    chk("no_stop", stops - p0, 0);
    chk("scl_held", scl_oe, 1'b1);
    chk("hi_ns", hi_ns, exp_hi(4, 0));
    $display("test write no stop done");
    wr(`I2M_OFF_CFG, 32'h00006401, `I2M_RESP_OKAY);
    seed = xs(seed);
    tx_en <= 1;
    tx_byte <= seed[7:0];
    cmd(F_RESTART | F_ACK);
    chk("rd_byte", st[15:8], seed[7:0]);
    chk("own_ack", st[1], 1'b0);
    chk("restarts", starts - s0, 1);
    chk("sda_oe", sda_oe, 1'b1);
    chk("hi_ns", hi_ns, exp_hi(4, 100));
    $display("test restart read done");
    wr(`I2M_OFF_CFG, 32'h0003e801, `I2M_RESP_OKAY);
    cmd(14'h0000);
    chk("rd_byte", st[15:8], tx_byte);
    chk("rd_nack", st[1], 1'b1);
    chk("rises", rises - r0, 9);
    chk("bare", starts - s0 + stops - p0, 0);
    chk("sda_oe", sda_oe, 1'b0);
    chk("hi_ns", hi_ns, exp_hi(1, 1000));
    tx_en <= 0;
    cmd(OP_AB);
    chk("abort_rises", rises - r0, 9);
    chk("abort_stop", stops - p0, 1);
    chk("released", {scl_oe, sda_oe}, 2'b00);
    $display("test bare read and abort done");
    repeat (3) begin
      seed = xs(seed);
      ack_en <= seed[8];
      cmd(F_START | F_STOP | OP_WR | {6'h0, seed[7:0]});
      chk("ack", st[1], !seed[8]);
      chk("rx_byte", rx_byte, seed[7:0]);
    end
    $display("test random writes done");
    final_report;
  end
endmodule
bind i2m_byte_master i2m_chk chk_u (.aclk, .aresetn, .link_clk, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .scl_o,
  .scl_oe, .sda_o, .sda_oe);
`default_nettype wire
